// ---- common/reset_cause_pkg.sv ----
// Constants shared by the reset cause flag logic.
// Assumes a 16-bit status register and a 3-bit oscillator select.
package reset_cause_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CTRL   = 4'h1;
  localparam logic [3:0] ADDR_OSC    = 4'h2;

  // ------------------------------------------------------------
  // Status register bit positions
  // ------------------------------------------------------------
  localparam int BIT_TRAP   = 15;
  localparam int BIT_ILLEG  = 14;
  localparam int BIT_CMIS   = 9;
  localparam int BIT_EXTCLR = 7;
  localparam int BIT_SOFT   = 6;
  localparam int BIT_WDOG   = 4;
  localparam int BIT_SLEEP  = 3;
  localparam int BIT_IDLE   = 2;
  localparam int BIT_BROWN  = 1;
  localparam int BIT_PWRON  = 0;

  // Implemented flags; other bits read zero
  localparam logic [15:0] FLAG_MASK = 16'hC2DF;

  // ------------------------------------------------------------
  // Control register bit positions
  // ------------------------------------------------------------
  localparam int CTRL_WDOG_SOFT  = 0;
  localparam int CTRL_BROWN_SOFT = 1;

  // Brown-out config field value that hands control to software
  localparam logic [1:0] BROWN_CFG_SOFT = 2'h1;

  typedef enum logic [2:0] {
    RST_NONE,
    RST_PWRON,
    RST_BROWN,
    RST_PIN,
    RST_WDOG,
    RST_SOFT
  } reset_kind_e;

endpackage

// ---- rtl/flag_cell.sv ----
// One sticky status flag: hardware set, hardware clear, software write.
// Assumes set/clear pulses are on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module flag_cell (
  input  wire logic sysClk,    // System clock
  input  wire logic rst,       // Sync reset, active high
  input  wire logic hwSet,     // Event pulse
  input  wire logic hwClr,     // Clearing event pulse
  input  wire logic swWe,      // Software write
  input  wire logic swVal,     // Software value
  output logic      flag       // Flag state
);
  logic flag_r;
  logic flag_nxt;

  // Set wins over any clear in the same cycle
  always_comb
  begin
    flag_nxt = flag_r;
    if (swWe)
      flag_nxt = swVal;
    if (hwClr)
      flag_nxt = 1'b0;
    if (hwSet)
      flag_nxt = 1'b1;
  end

  always_ff @(posedge sysClk)
  begin
    if (rst)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  assign flag = flag_r;
endmodule
`default_nettype wire

// ---- rtl/osc_select.sv ----
// Picks the system clock source latched at the end of each reset.
// Assumes reset kind is held valid while resetKind is not NONE.
`timescale 1ns/1ps
`default_nettype none
module osc_select (
  input  wire logic                        sysClk,     // System clock
  input  wire logic                        rst,        // Sync reset, active high
  input  wire reset_cause_pkg::reset_kind_e resetKind, // Reset being taken
  input  wire logic                        swEnable,   // Clock switching enabled
  input  wire logic [2:0]                  cfgOsc,     // Initial oscillator select
  input  wire logic [2:0]                  curOsc,     // Current oscillator field
  output logic      [2:0]                  oscSel      // Chosen source
);
  logic [2:0] oscSel_r;
  logic [2:0] oscSel_nxt;

  always_comb
  begin
    oscSel_nxt = oscSel_r;
    if (!swEnable)
    begin
      if (resetKind != reset_cause_pkg::RST_NONE)
        oscSel_nxt = cfgOsc;
    end
    else
    begin
      case (resetKind)
        reset_cause_pkg::RST_PWRON,
        reset_cause_pkg::RST_BROWN: oscSel_nxt = cfgOsc;
        reset_cause_pkg::RST_PIN,
        reset_cause_pkg::RST_WDOG,
        reset_cause_pkg::RST_SOFT:  oscSel_nxt = curOsc;
        default:                    oscSel_nxt = oscSel_r;
      endcase
    end
  end

  // Reset parks the source at zero; the power-on pulse after release loads it
  always_ff @(posedge sysClk)
  begin
    if (rst)
      oscSel_r <= 3'h0;
    else
      oscSel_r <= oscSel_nxt;
  end

  assign oscSel = oscSel_r;
endmodule
`default_nettype wire

// ---- rtl/reset_cause_flags.sv ----
// Reset cause flags, watchdog/brown-out enable overrides, clock source at reset.
// Assumes event inputs are one-cycle pulses from logic on sys_clk.
//
// What this block does
// - Sleep power-save instruction sets sleep flag bit 3; power-on or a software write clears it.
// - Idle power-save instruction sets idle flag bit 2; power-on or a software write clears it.
// - Brown-out flag bit 1 set by brown-out reset and by power-on reset.
// - Power-on flag bit 0 set by power-on reset; no hardware clear.
// - Software may write every flag; writing never causes a reset.
// - Watchdog config bit high keeps watchdog enabled regardless of soft bit.
// - Soft brown-out enable forced 0 unless config allows; then resets to 1.
// - Trap 15, illegal 14, mismatch 9, pin 7, reset instruction 6; power-on clears.
// - Clock switching off: source at reset from configuration bits always.
// - Clock switching on: source at reset depends on reset type.
// - Power-on/brown-out use config; pin, watchdog, software keep current field.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_flags (
  input  wire logic        sys_clk,       // System clock, 20 MHz
  input  wire logic        rst,           // Power-on reset, sync, active high
  input  wire logic [3:0]  regAddr,       // Register address
  input  wire logic [15:0] regWdata,      // Write data
  input  wire logic        regWr,         // Write strobe
  input  wire logic        regRd,         // Read strobe
  output logic      [15:0] regRdata,      // Read data, cycle after strobe
  input  wire logic        brownReset,    // Brown-out reset event
  input  wire logic        pinReset,      // Master clear pin reset event
  input  wire logic        softReset,     // Reset instruction event
  input  wire logic        wdogTimeout,   // Watchdog time-out event
  input  wire logic        trapConflict,  // Trap conflict event
  input  wire logic        illegalAccess, // Illegal opcode / uninit register
  input  wire logic        cfgMismatch,   // Configuration mismatch reset
  input  wire logic        sleepExec,     // Power-save sleep executed
  input  wire logic        idleExec,      // Power-save idle executed
  input  wire logic        wdogCfgEnable, // Watchdog config enable
  input  wire logic [1:0]  brownCfgField, // Brown-out config field
  input  wire logic        clkSwitchEn,   // Clock switching enabled
  input  wire logic [2:0]  initOscSelect, // Initial oscillator select bits
  input  wire logic [2:0]  curOscField,   // Current oscillator field
  output logic             wdogEnable,    // Effective watchdog enable
  output logic             brownEnable,   // Effective brown-out soft enable
  output logic      [2:0]  oscSource      // Clock source chosen at reset
);

  // ------------------------------------------------------------
  // Events
  // ------------------------------------------------------------
  logic [15:0] setVec;
  logic [15:0] clrVec;
  logic [15:0] flags;
  logic        statusWr;
  logic        pwrOnPend_r;
  logic        pwrOnPend_nxt;

  // Power-on is seen as the first cycle after rst releases, since rst wipes all flags
  always_comb
  begin
    pwrOnPend_nxt = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pwrOnPend_r <= 1'b1;
    else
      pwrOnPend_r <= pwrOnPend_nxt;
  end

  always_comb
  begin
    setVec = 16'h0000;
    clrVec = 16'h0000;
    setVec[reset_cause_pkg::BIT_SLEEP]  = sleepExec;
    setVec[reset_cause_pkg::BIT_IDLE]   = idleExec;
    setVec[reset_cause_pkg::BIT_BROWN]  = brownReset | pwrOnPend_r;
    setVec[reset_cause_pkg::BIT_PWRON]  = pwrOnPend_r;
    setVec[reset_cause_pkg::BIT_TRAP]   = trapConflict;
    setVec[reset_cause_pkg::BIT_ILLEG]  = illegalAccess;
    setVec[reset_cause_pkg::BIT_CMIS]   = cfgMismatch;
    setVec[reset_cause_pkg::BIT_EXTCLR] = pinReset;
    setVec[reset_cause_pkg::BIT_SOFT]   = softReset;
    setVec[reset_cause_pkg::BIT_WDOG]   = wdogTimeout;
    clrVec[reset_cause_pkg::BIT_WDOG]   = sleepExec | idleExec;
  end

  assign statusWr = regWr && (regAddr == reset_cause_pkg::ADDR_STATUS);

  // ------------------------------------------------------------
  // Flag cells
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_flag
      if (reset_cause_pkg::FLAG_MASK[gi])
      begin : g_impl
        // Writing a one only stores it; no reset request leaves here
        flag_cell u_cell (
          .sysClk (sys_clk),
          .rst    (rst),
          .hwSet  (setVec[gi]),
          .hwClr  (clrVec[gi]),
          .swWe   (statusWr),
          .swVal  (regWdata[gi]),
          .flag   (flags[gi])
        );
      end
      else
      begin : g_none
        assign flags[gi] = 1'b0;
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Enable bits
  // ------------------------------------------------------------
  logic wdogSoft_r;
  logic wdogSoft_nxt;
  logic brownSoft_r;
  logic brownSoft_nxt;
  logic brownAllowed;
  logic ctrlWr;

  assign ctrlWr       = regWr && (regAddr == reset_cause_pkg::ADDR_CTRL);
  assign brownAllowed = (brownCfgField == reset_cause_pkg::BROWN_CFG_SOFT);

  always_comb
  begin
    wdogSoft_nxt  = wdogSoft_r;
    brownSoft_nxt = brownSoft_r;
    if (ctrlWr)
    begin
      wdogSoft_nxt  = regWdata[reset_cause_pkg::CTRL_WDOG_SOFT];
      brownSoft_nxt = regWdata[reset_cause_pkg::CTRL_BROWN_SOFT];
    end
    // Reset value 1 arrives through the power-on pulse, config sampled after rst
    if (pwrOnPend_r)
      brownSoft_nxt = 1'b1;
    if (!brownAllowed)
      brownSoft_nxt = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wdogSoft_r  <= 1'b0;
      brownSoft_r <= 1'b0;
    end
    else
    begin
      wdogSoft_r  <= wdogSoft_nxt;
      brownSoft_r <= brownSoft_nxt;
    end
  end

  assign wdogEnable  = wdogCfgEnable | wdogSoft_r;
  assign brownEnable = brownSoft_r & brownAllowed;

  // ------------------------------------------------------------
  // Clock source at reset
  // ------------------------------------------------------------
  reset_cause_pkg::reset_kind_e resetKind;

  always_comb
  begin
    if (pwrOnPend_r)
      resetKind = reset_cause_pkg::RST_PWRON;
    else if (brownReset)
      resetKind = reset_cause_pkg::RST_BROWN;
    else if (pinReset)
      resetKind = reset_cause_pkg::RST_PIN;
    else if (wdogTimeout)
      resetKind = reset_cause_pkg::RST_WDOG;
    else if (softReset)
      resetKind = reset_cause_pkg::RST_SOFT;
    else
      resetKind = reset_cause_pkg::RST_NONE;
  end

  osc_select u_osc (
    .sysClk    (sys_clk),
    .rst       (rst),
    .resetKind (resetKind),
    .swEnable  (clkSwitchEn),
    .cfgOsc    (initOscSelect),
    .curOsc    (curOscField),
    .oscSel    (oscSource)
  );

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (regRd)
    begin
      case (regAddr)
        reset_cause_pkg::ADDR_STATUS: rdata_nxt = flags;
        reset_cause_pkg::ADDR_CTRL:
        begin
          rdata_nxt[reset_cause_pkg::CTRL_WDOG_SOFT]  = wdogSoft_r;
          rdata_nxt[reset_cause_pkg::CTRL_BROWN_SOFT] = brownSoft_r;
        end
        reset_cause_pkg::ADDR_OSC: rdata_nxt = {13'h0000, oscSource};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata_r <= 16'h0000;
    else
      rdata_r <= rdata_nxt;
  end

  assign regRdata = rdata_r;
endmodule
`default_nettype wire

// ---- tb/reset_cause_flags_monitor.sv ----
// Checker for the reset cause flag block, bound to its top module.
// Assumes register strobes are single-cycle pulses on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_flags_monitor (
  input wire logic        sys_clk,       // Clock
  input wire logic        rst,           // Reset
  input wire logic [3:0]  regAddr,       // Address
  input wire logic [15:0] regWdata,      // Write data
  input wire logic        regWr,         // Write strobe
  input wire logic        regRd,         // Read strobe
  input wire logic [15:0] regRdata,      // Read data
  input wire logic        brownReset,    // Event
  input wire logic        pinReset,      // Event
  input wire logic        softReset,     // Event
  input wire logic        wdogTimeout,   // Event
  input wire logic        trapConflict,  // Event
  input wire logic        illegalAccess, // Event
  input wire logic        cfgMismatch,   // Event
  input wire logic        sleepExec,     // Event
  input wire logic        idleExec,      // Event
  input wire logic        wdogCfgEnable, // Config
  input wire logic [1:0]  brownCfgField, // Config
  input wire logic        clkSwitchEn,   // Config
  input wire logic [2:0]  initOscSelect, // Config
  input wire logic [2:0]  curOscField,   // Current source
  input wire logic        wdogEnable,    // Output
  input wire logic        brownEnable,   // Output
  input wire logic [2:0]  oscSource      // Output
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_sleep_read;
    sleepExec ##[1:3] (regRd && regAddr == reset_cause_pkg::ADDR_STATUS);
  endsequence

  a_sleep_sticky: assert property (s_sleep_read |=> regRdata[3])
    else $error("sleep flag not seen on read");
  a_wdog_forced: assert property (wdogCfgEnable |-> wdogEnable)
    else $error("watchdog enable not forced");
  a_brown_forced: assert property (brownCfgField != 2'h1 |-> !brownEnable)
    else $error("brown-out soft enable not forced low");
  a_read_idle: assert property (!$past(regRd) |-> regRdata == 16'h0000)
    else $error("read data outside read cycle");
  a_read_unmapped: assert property (regRd && regAddr > 4'h2 |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  a_status_mask: assert property (
    regRd && regAddr == 4'h0 |=> (regRdata & ~reset_cause_pkg::FLAG_MASK) == 16'h0000)
    else $error("unimplemented status bit set");
  a_osc_noswitch: assert property (
    !clkSwitchEn && (brownReset || pinReset || softReset || wdogTimeout)
    |=> oscSource == $past(initOscSelect))
    else $error("clock source not from config");
  a_osc_keep: assert property (
    clkSwitchEn && !brownReset && (pinReset || softReset || wdogTimeout)
    |=> oscSource == $past(curOscField))
    else $error("clock source not kept");
  a_osc_brown: assert property (
    clkSwitchEn && brownReset |=> oscSource == $past(initOscSelect))
    else $error("brown-out clock source wrong");
endmodule
`default_nettype wire

// ---- tb/tb_reset_cause_flags.sv ----
// Self-checking bench for the reset cause flag block.
// Assumes the register port answers reads exactly one cycle later.
`timescale 1ns/1ps
`default_nettype none
module tb_reset_cause_flags;
  localparam logic [3:0] ST = reset_cause_pkg::ADDR_STATUS;
  localparam logic [3:0] CT = reset_cause_pkg::ADDR_CTRL;
  localparam int POS [9] = '{1, 7, 6, 4, 15, 14, 9, 3, 2};
  logic sys_clk, rst, regWr, regRd, wdogCfgEnable, clkSwitchEn;
  logic [3:0] regAddr;
  logic [15:0] regWdata;
  logic [1:0] brownCfgField;
  logic [2:0] initOscSelect, curOscField;
  logic [8:0] evt;
  wire logic [15:0] regRdata;
  wire logic wdogEnable, brownEnable;
  wire logic [2:0] oscSource;
  wire logic brownReset, pinReset, softReset, wdogTimeout, trapConflict;
  wire logic illegalAccess, cfgMismatch, sleepExec, idleExec;
  int failures, n_compared, cyc;
  assign {idleExec, sleepExec, cfgMismatch, illegalAccess, trapConflict,
          wdogTimeout, softReset, pinReset, brownReset} = evt;

  reset_cause_flags u_dut (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask

  task automatic rd(logic [3:0] a, logic [15:0] e, string nm);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chk(nm, e, regRdata);
  endtask

  task automatic pulse(int i);
    @(posedge sys_clk);
    evt <= 9'h001 << i;
    @(posedge sys_clk);
    evt <= 9'h000;
    #1;
  endtask

  task automatic t_power();
    rd(ST, 16'h0003, "status");
    rd(CT, 16'h0002, "ctrl");
    chk("osc", 16'(initOscSelect), 16'(oscSource));
    $display("test power done");
  endtask

  task automatic t_events();
    logic [15:0] e;
    e = 16'h0000;
    wr(ST, 16'h0000);
    for (int i = 0; i < 9; i++)
    begin
      pulse(i);
      e[POS[i]] = 1'b1;
      if (i >= 7)
        e[4] = 1'b0;
      rd(ST, e, "status");
    end
    $display("test events done");
  endtask

  task automatic t_soft();
    wr(CT, 16'h0000);
    wr(ST, 16'hFFFF);
    rd(ST, reset_cause_pkg::FLAG_MASK, "status");
    rd(CT, 16'h0000, "ctrl");
    wr(ST, 16'h0000);
    rd(ST, 16'h0000, "status");
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000, "unmapped");
    $display("test soft done");
  endtask

  task automatic t_enables();
    for (int f = 0; f < 4; f++)
    begin
      @(posedge sys_clk);
      brownCfgField <= 2'(f);
      wr(CT, 16'h0003);
      chk("brown", 16'(f == 1), 16'(brownEnable));
    end
    for (int c = 0; c < 3; c++)
    begin
      @(posedge sys_clk);
      wdogCfgEnable <= c[0];
      wr(CT, 16'(c[1]));
      chk("wdog", 16'(c != 0), 16'(wdogEnable));
    end
    $display("test enables done");
  endtask

  task automatic t_osc();
    for (int j = 0; j < 8; j++)
    begin
      @(posedge sys_clk);
      clkSwitchEn <= j[2];
      pulse(j % 4);
      chk("osc", (j < 4 || j == 4) ? 16'h0003 : 16'h0005, 16'(oscSource));
    end
    $display("test osc done");
  endtask

  task automatic t_rerst();
    pulse(4);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(ST, 16'h0003, "status");
    rd(CT, 16'h0000, "ctrl");
    chk("osc", 16'h0003, 16'(oscSource));
    $display("test rerst done");
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard: the whole run needs about 140 cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      final_report();
    end
  end

  initial
  begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    evt = 9'h000;
    wdogCfgEnable = 1'b0;
    brownCfgField = 2'h1;
    clkSwitchEn = 1'b1;
    initOscSelect = 3'h3;
    curOscField = 3'h5;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    t_power();
    t_events();
    t_soft();
    t_enables();
    t_osc();
    t_rerst();
    final_report();
  end
endmodule

bind reset_cause_flags reset_cause_flags_monitor u_mon (.*);
`default_nettype wire
